// file: design/pbt_pkg.sv
/*
  Constants and carrier types for the process batch totalizer.
  Assumes a 10 MHz system clock and an external wall-clock source.
*/
// Overview of operation
// - Up counting starts at the start value and advances toward the target.
// - With rollover on, reaching target reloads the total with the start value.
// - With rollover off, reaching target halts counting, total held at target.
// - With rollover on, each target hit gives a two-second rollover pulse.
// - With rollover off, rollover output rises at target and holds until clear.
// - Keep-previous restore policy resumes the running or halted state held before.
// - Halt policy stays halted after restore; run policy resumes from saved total.
// - Run input rising edge starts, falling edge stops; levels do nothing.
// - Clear input rising edge loads the total with the start value.
// - Warning output activates when the total reaches the intermediate value.
// - Snapshot input rising edge emits the current total as a log record.
// - Periodic log records align to minutes past the hour, to hours of the day divisible by the period, or to midnight.
// - Analog source accumulates pulses at a rate proportional to the value.
// - Digital source counts each off-to-on transition.
// - Each digital transition changes the total by the configured pulse weight.
// - Analog accumulation is suppressed while the value is below the cut-off.
package pbt_pkg;

  // ==========================================================================
  // Widths and timing
  localparam int TOT_W        = 40;
  localparam int WGT_W        = 27;
  localparam int ANA_W        = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_NS = 1000000000;
  localparam int TICK_CYC     = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int ROLL_PULSE_S = 2;

  // ==========================================================================
  // Reset values
  localparam logic [TOT_W-1:0] TOTAL_RST = 40'h00_0000_0000;
  localparam logic [ANA_W-1:0] PHASE_RST = 16'h0000;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {PBT_RESTORE_LAST, PBT_RESTORE_HALT, PBT_RESTORE_RUN} pbt_restore_t;

  typedef enum logic [3:0] {
    PBT_LOG_OFF, PBT_LOG_5M, PBT_LOG_10M, PBT_LOG_15M, PBT_LOG_20M, PBT_LOG_30M, PBT_LOG_60M,
    PBT_LOG_2H, PBT_LOG_3H, PBT_LOG_4H, PBT_LOG_8H, PBT_LOG_12H, PBT_LOG_24H
  } pbt_period_t;

  typedef struct packed {
    logic [TOT_W-1:0] start_val;
    logic [TOT_W-1:0] target_val;
    logic [TOT_W-1:0] inter_val;
    logic [WGT_W-1:0] weight;
    logic [ANA_W-1:0] cutoff;
    logic             count_down;
    logic             wrap_en;
    logic             src_digital;
    pbt_restore_t     restore;
    pbt_period_t      log_period;
  } pbt_cfg_t;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } pbt_wall_t;

  typedef struct packed {
    logic             valid;
    logic             periodic;
    logic [TOT_W-1:0] total;
  } pbt_log_t;

endpackage

// file: design/pbt_totalizer.sv
/*
  Batch totalizer core for one recording channel.
  Assumes all inputs synchronous to sys_clk_i and configuration held stable by software.
*/
`timescale 1ns/100ps
module pbt_totalizer #(
  parameter int TICK_CYC = pbt_pkg::TICK_CYC
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        ce_i,
  input  wire pbt_pkg::pbt_cfg_t           cfg_i,
  input  wire pbt_pkg::pbt_wall_t          wall_i,
  input  wire logic [pbt_pkg::ANA_W-1:0]   analog_i,
  input  wire logic                        digital_i,
  input  wire logic                        run_i,
  input  wire logic                        clear_i,
  input  wire logic                        snap_i,
  input  wire logic                        restore_i,
  output logic [pbt_pkg::TOT_W-1:0]        total_o,
  output logic                             running_o,
  output logic                             rollover_o,
  output logic                             warn_o,
  output pbt_pkg::pbt_log_t                log_o
);

  // ==========================================================================
  // Helpers
  localparam int ROLL_CYC = pbt_pkg::ROLL_PULSE_S * TICK_CYC;

  function automatic logic aligned(input pbt_pkg::pbt_period_t p, input pbt_pkg::pbt_wall_t w);
    logic hr0;
    hr0 = (w.minute == 6'h00);
    case (p)
      pbt_pkg::PBT_LOG_5M:  aligned = (w.minute % 6'd5) == 6'h00;
      pbt_pkg::PBT_LOG_10M: aligned = (w.minute % 6'd10) == 6'h00;
      pbt_pkg::PBT_LOG_15M: aligned = (w.minute % 6'd15) == 6'h00;
      pbt_pkg::PBT_LOG_20M: aligned = (w.minute % 6'd20) == 6'h00;
      pbt_pkg::PBT_LOG_30M: aligned = (w.minute % 6'd30) == 6'h00;
      pbt_pkg::PBT_LOG_60M: aligned = hr0;
      pbt_pkg::PBT_LOG_2H:  aligned = hr0 && ((w.hour % 5'd2) == 5'h00);
      pbt_pkg::PBT_LOG_3H:  aligned = hr0 && ((w.hour % 5'd3) == 5'h00);
      pbt_pkg::PBT_LOG_4H:  aligned = hr0 && ((w.hour % 5'd4) == 5'h00);
      pbt_pkg::PBT_LOG_8H:  aligned = hr0 && ((w.hour % 5'd8) == 5'h00);
      pbt_pkg::PBT_LOG_12H: aligned = hr0 && ((w.hour % 5'd12) == 5'h00);
      pbt_pkg::PBT_LOG_24H: aligned = hr0 && (w.hour == 5'h00);
      default:              aligned = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // State
  logic                       armed_q;
  logic                       run_prev_q;
  logic                       clr_prev_q;
  logic                       snap_prev_q;
  logic                       dig_prev_q;
  logic [pbt_pkg::ANA_W-1:0]  phase_q;
  logic [31:0]                tick_cnt_q;
  logic [31:0]                roll_cnt_q;
  logic [5:0]                 last_min_q;

  // ==========================================================================
  // Edge and pulse decode
  // Edges wait one enabled cycle after reset so a level present at release is not taken as an edge
  wire run_rise  = armed_q && run_i && !run_prev_q;
  wire run_fall  = armed_q && !run_i && run_prev_q;
  wire clr_rise  = armed_q && clear_i && !clr_prev_q;
  wire snap_rise = armed_q && snap_i && !snap_prev_q;
  wire dig_rise  = armed_q && digital_i && !dig_prev_q;

  wire [pbt_pkg::ANA_W:0] phase_sum = {1'b0, phase_q} + {1'b0, analog_i};
  wire above_cut  = analog_i >= cfg_i.cutoff;
  wire ana_pulse  = phase_sum[pbt_pkg::ANA_W] && above_cut;
  wire cnt_pulse  = cfg_i.src_digital ? dig_rise : ana_pulse;
  wire step       = running_o && cnt_pulse;

  wire [pbt_pkg::TOT_W:0] inc     = {{(pbt_pkg::TOT_W-pbt_pkg::WGT_W+1){1'b0}}, cfg_i.weight};
  wire [pbt_pkg::TOT_W:0] up_sum  = {1'b0, total_o} + inc;
  wire [pbt_pkg::TOT_W:0] dn_dif  = {1'b0, total_o} - inc;
  wire                    up_hit  = up_sum >= {1'b0, cfg_i.target_val};
  wire                    dn_hit  = dn_dif[pbt_pkg::TOT_W] || (dn_dif <= {1'b0, cfg_i.target_val});
  // Clear in the same cycle wins, so no hit, halt or rollover comes with it
  wire                    hit     = step && !clr_rise && (cfg_i.count_down ? dn_hit : up_hit);
  wire [pbt_pkg::TOT_W-1:0] stepped = cfg_i.count_down ? dn_dif[pbt_pkg::TOT_W-1:0]
                                                       : up_sum[pbt_pkg::TOT_W-1:0];
  wire [pbt_pkg::TOT_W-1:0] hit_val = cfg_i.wrap_en ? cfg_i.start_val : cfg_i.target_val;

  logic [pbt_pkg::TOT_W-1:0] total_d;
  assign total_d = clr_rise ? cfg_i.start_val : hit ? hit_val : step ? stepped : total_o;

  wire halted_hit = hit && !cfg_i.wrap_en;
  wire warn_d = cfg_i.count_down ? (total_d <= cfg_i.inter_val) : (total_d >= cfg_i.inter_val);

  wire tick     = tick_cnt_q == 32'(TICK_CYC - 1);
  wire per_log  = tick && (wall_i.second == 6'h00) && (last_min_q != wall_i.minute)
                  && aligned(cfg_i.log_period, wall_i);

  logic running_d;
  always_comb
  begin
    running_d = running_o;
    if (restore_i)
    begin
      case (cfg_i.restore)
        pbt_pkg::PBT_RESTORE_HALT: running_d = 1'b0;
        pbt_pkg::PBT_RESTORE_RUN:  running_d = 1'b1;
        default:                   running_d = running_o;
      endcase
    end
    else if (halted_hit)
      running_d = 1'b0;
    else if (run_rise)
      running_d = 1'b1;
    else if (run_fall)
      running_d = 1'b0;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      armed_q     <= 1'b0;
      run_prev_q  <= 1'b0;
      clr_prev_q  <= 1'b0;
      snap_prev_q <= 1'b0;
      dig_prev_q  <= 1'b0;
      phase_q     <= pbt_pkg::PHASE_RST;
      total_o     <= pbt_pkg::TOTAL_RST;
      running_o   <= 1'b0;
      warn_o      <= 1'b0;
    end
    else if (ce_i)
    begin
      armed_q     <= 1'b1;
      run_prev_q  <= run_i;
      clr_prev_q  <= clear_i;
      snap_prev_q <= snap_i;
      dig_prev_q  <= digital_i;
      phase_q     <= phase_sum[pbt_pkg::ANA_W-1:0];
      total_o     <= total_d;
      running_o   <= running_d;
      warn_o      <= warn_d;
    end
  end

  // Restore leaves the total alone: the saved value is simply kept
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tick_cnt_q <= 32'h0000_0000;
      roll_cnt_q <= 32'h0000_0000;
      rollover_o <= 1'b0;
      last_min_q <= 6'h3F;
    end
    else if (ce_i)
    begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (hit && cfg_i.wrap_en)
      begin
        roll_cnt_q <= 32'(ROLL_CYC - 1);
        rollover_o <= 1'b1;
      end
      else if (halted_hit)
        rollover_o <= 1'b1;
      else if (clr_rise)
      begin
        roll_cnt_q <= 32'h0000_0000;
        rollover_o <= 1'b0;
      end
      else if (roll_cnt_q != 32'h0000_0000)
        roll_cnt_q <= roll_cnt_q - 32'h0000_0001;
      else if (cfg_i.wrap_en)
        rollover_o <= 1'b0;
      // Minute seen at every tick: hourly periods repeat the same minute value
      if (tick)
        last_min_q <= wall_i.minute;
    end
  end

  // Snapshot wins the slot when both occur; the periodic record is dropped and the one record is marked non-periodic
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      log_o <= '0;
    else if (ce_i)
    begin
      log_o.valid    <= snap_rise || per_log;
      log_o.periodic <= per_log && !snap_rise;
      log_o.total    <= total_o;
    end
    else
      log_o.valid <= 1'b0;
  end

  // ==========================================================================
  // Checks
  property p_clear;
    @(posedge sys_clk_i) disable iff (!resetn_i) ce_i && clr_rise |=> total_o == $past(cfg_i.start_val);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not load start");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ce_i && hit && cfg_i.wrap_en && !clr_rise |=> total_o == $past(cfg_i.start_val) && rollover_o;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not reload start");

  property p_halt;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ce_i && halted_hit && !clr_rise |=> total_o == $past(cfg_i.target_val) && !running_o && rollover_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt at target failed");

  property p_roll_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      rollover_o && !cfg_i.wrap_en && !(ce_i && clr_rise) |=> rollover_o;
  endproperty
  a_roll_hold: assert property (p_roll_hold) else $error("latched rollover dropped");

  property p_roll_len;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      roll_cnt_q != 32'h0000_0000 |-> rollover_o;
  endproperty
  a_roll_len: assert property (p_roll_len) else $error("rollover pulse ended early");

  property p_run;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ce_i && run_rise && !restore_i && !halted_hit |=> running_o;
  endproperty
  a_run: assert property (p_run) else $error("run edge did not start");

  property p_stop;
    @(posedge sys_clk_i) disable iff (!resetn_i) ce_i && run_fall && !restore_i |=> !running_o;
  endproperty
  a_stop: assert property (p_stop) else $error("run fall did not stop");

  property p_snap;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ce_i && snap_rise |=> log_o.valid && !log_o.periodic && log_o.total == $past(total_o);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot record missing");

  property p_cut;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ce_i && !cfg_i.src_digital && !above_cut && !clr_rise |=> $stable(total_o);
  endproperty
  a_cut: assert property (p_cut) else $error("counted below cut-off");

  property p_restore;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ce_i && restore_i && cfg_i.restore == pbt_pkg::PBT_RESTORE_LAST |=> running_o == $past(running_o);
  endproperty
  a_restore: assert property (p_restore) else $error("keep-previous restore changed state");

endmodule

// file: tb/pbt_src_model.sv
/*
  Far-side model: a digital event source and a relay fed by the rollover output.
  Assumes one clock shared with the totalizer; the source is always driven.
*/
`timescale 1ns/100ps
module pbt_src_model (
  input  wire logic clk_i,
  input  wire logic relay_i,
  output logic      dig_o,
  output int        relay_len_o
);
  // ==========================================================================
  // Relay on-time, in clock cycles
  int cnt;
  initial
  begin
    dig_o       = 1'b0;
    relay_len_o = 0;
    cnt         = 0;
  end
  always @(posedge clk_i)
  begin
    if (relay_i)
      cnt <= cnt + 1;
    else
    begin
      if (cnt != 0)
        relay_len_o <= cnt;
      cnt <= 0;
    end
  end

  // ==========================================================================
  // One off-to-on event; low again so the next one is a fresh edge
  task automatic emit;
    @(posedge clk_i);
    dig_o <= 1'b1;
    @(posedge clk_i);
    dig_o <= 1'b0;
  endtask
endmodule

// file: tb/pbt_totalizer_tb.sv
/*
  Self-checking bench for the batch totalizer core.
  Assumes a short tick parameter so the two-second pulse fits a brief run.
*/
`timescale 1ns/100ps
module pbt_totalizer_tb;
  // ==========================================================================
  // Stimulus and observation
  localparam int T = 20;
  logic                sys_clk_i, resetn_i, run_i, clear_i, snap_i, restore_i, dig, ce;
  pbt_pkg::pbt_cfg_t   cfg;
  pbt_pkg::pbt_wall_t  wall;
  logic [15:0]         analog;
  logic [39:0]         total_o, t0;
  logic                running_o, rollover_o, warn_o, found, per;
  pbt_pkg::pbt_log_t   log_o;
  int                  mismatches, tests_run, rl;

  pbt_totalizer #(.TICK_CYC(T)) uut (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce),
    .cfg_i      (cfg),
    .wall_i     (wall),
    .analog_i   (analog),
    .digital_i  (dig),
    .run_i      (run_i),
    .clear_i    (clear_i),
    .snap_i     (snap_i),
    .restore_i  (restore_i),
    .total_o    (total_o),
    .running_o  (running_o),
    .rollover_o (rollover_o),
    .warn_o     (warn_o),
    .log_o      (log_o)
  );
  pbt_src_model src (.clk_i(sys_clk_i), .relay_i(rollover_o), .dig_o(dig), .relay_len_o(rl));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // 0 run level, 1 clear, 2 snapshot, 3 restore; edges land at the second clock edge
  task automatic step(input int w, input logic v);
    @(posedge sys_clk_i);
    case (w)
      0: run_i <= v;
      1: clear_i <= v;
      2: snap_i <= v;
      default: restore_i <= v;
    endcase
    @(posedge sys_clk_i);
    clear_i   <= 1'b0;
    snap_i    <= 1'b0;
    restore_i <= 1'b0;
    #1;
  endtask
  task automatic emit_chk(input logic [39:0] exp);
    src.emit();
    #1;
    check(total_o, exp);
  endtask
  task automatic setup(input logic [39:0] s, t, m, input logic [26:0] w, input logic d, r, g);
    pbt_pkg::pbt_cfg_t c;
    c = cfg;
    c.start_val   = s;
    c.target_val  = t;
    c.inter_val   = m;
    c.weight      = w;
    c.count_down  = d;
    c.wrap_en     = r;
    c.src_digital = g;
    c.cutoff      = 16'h4000;
    @(posedge sys_clk_i);
    cfg <= c;
  endtask
  task automatic restore_chk(input pbt_pkg::pbt_restore_t p, input logic exp);
    @(posedge sys_clk_i);
    cfg.restore <= p;
    step(3, 1'b1);
    tick(1);
    check(running_o, exp);
  endtask
  task automatic watch_log;
    found = 1'b0;
    per   = 1'b0;
    repeat (3 * T)
    begin
      tick(1);
      if (log_o.valid === 1'b1)
      begin
        found = 1'b1;
        per   = log_o.periodic;
      end
    end
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    mismatches++;
    end_of_test();
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    {resetn_i, run_i, clear_i, snap_i, restore_i} = '0;
    ce = 1'b1;
    cfg = '0;
    wall = '{5'h03, 6'h07, 6'h01};
    analog = 16'h0000;
    mismatches = 0;
    tests_run = 0;
    setup(40'h0A, 40'h28, 40'h1E, 27'h0A, 1'b0, 1'b1, 1'b1);
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    #1;
    check({total_o, running_o, rollover_o, warn_o}, '0);
    tick(2);
    step(1, 1'b1); check(total_o, 40'h0A);
    step(0, 1'b1); check(running_o, 1'b1);
    emit_chk(40'h14); check(warn_o, 1'b0);
    emit_chk(40'h1E); check(warn_o, 1'b1);
    emit_chk(40'h0A); check(rollover_o, 1'b1);
    step(2, 1'b1); check({log_o.valid, log_o.periodic, log_o.total}, {2'b10, 40'h0A});
    tick(2 * T + 4);
    check(rl >= 2 * T && rl <= 2 * T + 1, 1'b1);
    step(0, 1'b0); check(running_o, 1'b0);
    emit_chk(40'h0A);
    restore_chk(pbt_pkg::PBT_RESTORE_RUN, 1'b1); check(total_o, 40'h0A);
    restore_chk(pbt_pkg::PBT_RESTORE_LAST, 1'b1);
    restore_chk(pbt_pkg::PBT_RESTORE_HALT, 1'b0);
    restore_chk(pbt_pkg::PBT_RESTORE_LAST, 1'b0);
    // Down count without wrap: halt and latched rollover
    setup(40'h32, 40'h14, 40'h23, 27'h0F, 1'b1, 1'b0, 1'b1);
    step(1, 1'b1); check(total_o, 40'h32);
    step(0, 1'b1);
    // Frozen while the enable is low: an event in that time is not counted
    @(posedge sys_clk_i);
    ce <= 1'b0;
    src.emit();
    ce <= 1'b1;
    tick(1); check(total_o, 40'h32);
    emit_chk(40'h23); check(warn_o, 1'b1);
    emit_chk(40'h14); check({running_o, rollover_o}, 2'b01);
    tick(3 * T);
    check(rollover_o, 1'b1);
    emit_chk(40'h14);
    step(1, 1'b1); check({total_o, rollover_o}, {40'h32, 1'b0});
    // Analog source, below and above the cut-off
    step(0, 1'b0);
    setup(40'h00, 40'hFF_FFFF_FFFF, 40'hFF_FFFF_FFFF, 27'h01, 1'b0, 1'b1, 1'b0);
    analog <= 16'h3FFF;
    step(1, 1'b1);
    step(0, 1'b1);
    tick(100); check(total_o, 40'h00);
    t0 = total_o;
    @(posedge sys_clk_i);
    analog <= 16'h8000;
    tick(128);
    t0 = total_o - t0;
    check(t0 >= 40'h3F && t0 <= 40'h41, 1'b1);
    // Periodic log: misaligned minute gives nothing, aligned one logs
    @(posedge sys_clk_i);
    analog <= 16'h0000;
    cfg.log_period <= pbt_pkg::PBT_LOG_5M;
    wall <= '{5'h03, 6'h07, 6'h00};
    watch_log(); check(found, 1'b0);
    @(posedge sys_clk_i);
    wall <= '{5'h03, 6'h0A, 6'h00};
    watch_log(); check({found, per}, 2'b11);
    // Two-hour period: odd hour quiet, next even hour logs
    @(posedge sys_clk_i);
    cfg.log_period <= pbt_pkg::PBT_LOG_2H;
    wall <= '{5'h03, 6'h00, 6'h00};
    watch_log(); check(found, 1'b0);
    @(posedge sys_clk_i);
    wall <= '{5'h03, 6'h3B, 6'h00};
    watch_log(); check(found, 1'b0);
    @(posedge sys_clk_i);
    wall <= '{5'h04, 6'h00, 6'h00};
    watch_log(); check({found, per}, 2'b11);
    // Hourly period: the same minute an hour later must log again
    @(posedge sys_clk_i);
    cfg.log_period <= pbt_pkg::PBT_LOG_60M;
    wall <= '{5'h04, 6'h3B, 6'h00};
    watch_log(); check(found, 1'b0);
    @(posedge sys_clk_i);
    wall <= '{5'h05, 6'h00, 6'h00};
    watch_log(); check({found, per}, 2'b11);
    end_of_test();
  end
endmodule
